// File: design/eee_port_status_regs.sv
// Operation
// R1 - Control bits 7:5 equal to 001 route indirect access to EEE space
// R2 - Control bits 3:0 pick the port; only ports 3 and 4 respond
// R3 - Offset byte selects which register byte appears at data window 0xA0
// R4 - Ability register high byte at offset 0x28, low byte at 0x29
// R5 - Wake error counter high byte at 0x2A, low byte at 0x2B
// R6 - Bits 14:9 are read-only link partner EEE flags, reset zero
// R7 - Bit 1 is writable local 100BASE-TX advertisement, reset one
// R8 - Counter adds one per wake from LPI longer than threshold
// R9 - Wake threshold defaults to 20.5 us
// R10 - Counter resets to zero and clears when read
// R11 - Counter saturates; reserved ability bits read zero, ignore writes
`timescale 1ns/1ns
`default_nettype none
module eee_port_status_regs #(
    parameter int WAKE_THRESH = eee_port_pkg::WAKE_THRESH_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire eee_port_pkg::host_req_t req_in,
    input wire eee_port_pkg::port_phy_t [1:0] phy_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic [1:0] local_tx_adv_out
);
    import eee_port_pkg::*;

    // Wake timer cannot measure a threshold below one cycle
    if (WAKE_THRESH < 1)
    begin : g_bad_thresh
        $error("wake threshold must be at least one cycle");
    end

    logic [7:0] ctrl;
    logic [7:0] offset;
    logic [5:0] partner [NUM_PORTS];
    logic [1:0] local_tx;
    logic [15:0] wake_cnt [NUM_PORTS];
    logic [1:0] clear_req;

    function automatic logic [15:0] ability_word(input logic [5:0] p, input logic l);
        logic [15:0] w;
        w = '0;
        w[PARTNER_MSB:PARTNER_LSB] = p; // R6
        w[LOCAL_TX_BIT] = l; // R7 R11
        return w;
    endfunction : ability_word

    wire table_eee = (ctrl[TABLE_MSB:TABLE_LSB] == TABLE_EEE); // R1
    wire [3:0] port_sel = ctrl[PORT_MSB:0];
    wire port_ok = (port_sel >= PORT_FIRST) && (port_sel <= PORT_LAST); // R2
    // Port 3 maps to slot 0, port 4 to slot 1
    wire idx = (port_sel == PORT_LAST);
    wire window_hit = table_eee && port_ok;
    wire data_rd = req_in.rd && (req_in.addr == DATA_ADDR); // R3
    wire data_wr = req_in.wr && (req_in.addr == DATA_ADDR); // R3
    wire [15:0] ability = ability_word(partner[idx], local_tx[idx]);
    wire [15:0] wake_sel = wake_cnt[idx];
    logic [7:0] window_byte;

    always_comb
    begin
        window_byte = 8'h00;
        if (window_hit)
        begin
            unique case (offset)
                ABILITY_HI: window_byte = ability[15:8]; // R4
                ABILITY_LO: window_byte = ability[7:0]; // R4
                WAKE_ERR_HI: window_byte = wake_sel[15:8]; // R5
                WAKE_ERR_LO: window_byte = wake_sel[7:0]; // R5
                default: window_byte = 8'h00;
            endcase
        end
    end

    wire [7:0] next_rdata = (req_in.addr == CTRL_ADDR) ? ctrl :
        (req_in.addr == OFFSET_ADDR) ? offset : (req_in.addr == DATA_ADDR) ? window_byte : 8'h00;
    // Clear after low byte read so a high-then-low read sees one value
    wire wake_read = data_rd && window_hit && (offset == WAKE_ERR_LO); // R10
    assign clear_req = {wake_read && idx, wake_read && !idx};

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            ctrl <= 8'h00;
            offset <= 8'h00;
            local_tx <= {2{LOCAL_TX_RESET}}; // R7
            rdata_out <= 8'h00;
            rvalid_out <= 1'b0;
            local_tx_adv_out <= {2{LOCAL_TX_RESET}};
        end
        else
        begin
            if (req_in.wr && req_in.addr == CTRL_ADDR)
                ctrl <= req_in.wdata; // R1 R2
            if (req_in.wr && req_in.addr == OFFSET_ADDR)
                offset <= req_in.wdata; // R3
            if (data_wr && window_hit && offset == ABILITY_LO)
                local_tx[idx] <= req_in.wdata[LOCAL_TX_BIT]; // R7
            rdata_out <= req_in.rd ? next_rdata : rdata_out;
            rvalid_out <= req_in.rd;
            local_tx_adv_out <= local_tx;
        end
    end

    genvar g;
    generate
        // One flop on partner flags so a host read sees a settled value
        for (g = 0; g < NUM_PORTS; g++)
        begin : g_port
            always_ff @(posedge ref_clk_in)
            begin
                if (!nrst_in)
                    partner[g] <= '0; // R6
                else
                    partner[g] <= phy_in[g].partner; // R6
            end

            eee_wake_monitor #(
                .THRESH_CYCLES(WAKE_THRESH)
            ) u_wake (
                .ref_clk_in(ref_clk_in),
                .nrst_in(nrst_in),
                .lpi_in(phy_in[g].lpi),
                .clear_in(clear_req[g]),
                .count_out(wake_cnt[g])
            );
        end
    endgenerate

    sequence s_read_low;
        data_rd && window_hit && offset == WAKE_ERR_LO;
    endsequence

    sequence s_read_ability_lo;
        data_rd && window_hit && offset == ABILITY_LO;
    endsequence

    sequence s_write_ability_lo;
        data_wr && window_hit && offset == ABILITY_LO;
    endsequence

    // An increment in the read cycle wins over the clear
    chk_read_clears: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R10
        s_read_low |=> rvalid_out && (wake_sel == WAKE_ERR_RESET || wake_sel == $past(wake_sel) + 16'h0001
            || $past(wake_sel) == WAKE_ERR_MAX))
        else $error("wake counter not cleared by read");

    chk_ctrl_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R1 R2
        req_in.wr && req_in.addr == CTRL_ADDR |=> ctrl == $past(req_in.wdata))
        else $error("control byte not written");

    chk_offset_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R3
        req_in.wr && req_in.addr == OFFSET_ADDR |=> offset == $past(req_in.wdata))
        else $error("offset byte not written");

    chk_ctrl_readback: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R1 R2
        req_in.rd && req_in.addr == CTRL_ADDR |=> rdata_out == $past(ctrl))
        else $error("control byte read back wrong");

    chk_offset_readback: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R3
        req_in.rd && req_in.addr == OFFSET_ADDR |=> rdata_out == $past(offset))
        else $error("offset byte read back wrong");

    chk_rvalid_pulse: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R3
        1'b1 |=> rvalid_out == $past(req_in.rd))
        else $error("read valid not a one-cycle answer");

    chk_rdata_holds: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R3
        !req_in.rd |=> $stable(rdata_out))
        else $error("read data changed without a read");

    chk_unmapped_zero: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R3
        data_rd && offset != ABILITY_HI && offset != ABILITY_LO && offset != WAKE_ERR_HI && offset != WAKE_ERR_LO
            |=> rdata_out == 8'h00)
        else $error("unmapped offset answered");

    chk_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R11
        data_rd && window_hit && (offset == ABILITY_HI || offset == ABILITY_LO)
            |=> (rdata_out & ($past(offset) == ABILITY_HI ? 8'h81 : 8'hFD)) == 8'h00)
        else $error("reserved ability bit set");

    chk_wrong_table: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R1
        req_in.rd && req_in.addr == DATA_ADDR && !table_eee |=> rdata_out == 8'h00)
        else $error("data seen outside EEE table");

    chk_bad_port: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R2
        req_in.rd && req_in.addr == DATA_ADDR && !port_ok |=> rdata_out == 8'h00)
        else $error("invalid port answered");

    chk_ability_hi: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R4
        data_rd && window_hit && offset == ABILITY_HI |=> rdata_out == $past(ability[15:8]))
        else $error("ability high byte wrong");

    chk_ability_lo: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R4
        s_read_ability_lo |=> rdata_out == $past(ability[7:0]))
        else $error("ability low byte wrong");

    chk_wake_hi: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R5
        data_rd && window_hit && offset == WAKE_ERR_HI |=> rdata_out == $past(wake_sel[15:8]))
        else $error("wake high byte wrong");

    chk_wake_lo: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R5
        s_read_low |=> rdata_out == $past(wake_sel[7:0]))
        else $error("wake low byte wrong");

    chk_local_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R7
        s_write_ability_lo |=> ##1 local_tx_adv_out[$past(idx, 2)] == $past(req_in.wdata[LOCAL_TX_BIT], 2))
        else $error("local advertisement not written");

    chk_write_ignored: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R6 R11
        data_wr && !(window_hit && offset == ABILITY_LO) |=> $stable(local_tx))
        else $error("read-only ability bits took a write");

    chk_adv_follows: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R7
        1'b1 |=> local_tx_adv_out == $past(local_tx))
        else $error("advertisement output stale");

    chk_partner_follow: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R6
        1'b1 |=> partner[0] == $past(phy_in[0].partner))
        else $error("partner flags stale");

    chk_partner_port4: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R6
        1'b1 |=> partner[1] == $past(phy_in[1].partner))
        else $error("second port partner flags stale");
endmodule : eee_port_status_regs
`default_nettype wire

// File: design/eee_port_pkg.sv
`default_nettype none
package eee_port_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h6E;
    localparam logic [7:0] OFFSET_ADDR = 8'h6F;
    localparam logic [7:0] DATA_ADDR = 8'hA0;
    localparam logic [2:0] TABLE_EEE = 3'h1;
    localparam int TABLE_MSB = 7;
    localparam int TABLE_LSB = 5;
    localparam int PORT_MSB = 3;
    localparam logic [3:0] PORT_FIRST = 4'h3;
    localparam logic [3:0] PORT_LAST = 4'h4;
    localparam int NUM_PORTS = 2;
    localparam logic [7:0] ABILITY_HI = 8'h28;
    localparam logic [7:0] ABILITY_LO = 8'h29;
    localparam logic [7:0] WAKE_ERR_HI = 8'h2A;
    localparam logic [7:0] WAKE_ERR_LO = 8'h2B;
    localparam int PARTNER_MSB = 14;
    localparam int PARTNER_LSB = 9;
    localparam int LOCAL_TX_BIT = 1;
    localparam logic LOCAL_TX_RESET = 1'b1;
    localparam logic [15:0] WAKE_ERR_RESET = 16'h0000;
    localparam logic [15:0] WAKE_ERR_MAX = 16'hFFFF;
    localparam real WAKE_THRESH_NS = 20500.0;
    localparam real CLK_PERIOD_NS = 20.0;
    localparam int WAKE_THRESH_CYCLES = int'(WAKE_THRESH_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [5:0] partner;
        logic lpi;
    } port_phy_t;
endpackage : eee_port_pkg
`default_nettype wire

// File: design/eee_wake_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module eee_wake_monitor #(
    parameter int THRESH_CYCLES = eee_port_pkg::WAKE_THRESH_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic lpi_in,
    input wire logic clear_in,
    output logic [15:0] count_out
);
    import eee_port_pkg::*;
    localparam int CW = $clog2(THRESH_CYCLES + 2);

    if (THRESH_CYCLES < 1)
    begin : g_bad_thresh
        $error("threshold must be at least one cycle");
    end

    logic lpi_d;
    logic waking;
    logic [CW-1:0] wake_len;
    logic over_thresh;
    logic flagged;
    wire leave_lpi = lpi_d && !lpi_in;
    wire too_long = waking && over_thresh && !flagged;
    wire saturated = (count_out == WAKE_ERR_MAX);

    // Wake counted from LPI exit until threshold or LPI re-entry; a long wake flags once
    assign over_thresh = (wake_len >= CW'(THRESH_CYCLES)); // R9

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            lpi_d <= 1'b0;
            waking <= 1'b0;
            wake_len <= '0;
            flagged <= 1'b0;
            count_out <= WAKE_ERR_RESET; // R10
        end
        else
        begin
            lpi_d <= lpi_in;
            if (leave_lpi)
                waking <= 1'b1;
            else if (over_thresh || lpi_in)
                waking <= 1'b0;
            wake_len <= leave_lpi ? CW'(1) : (waking && !over_thresh ? wake_len + CW'(1) : wake_len);
            flagged <= leave_lpi ? 1'b0 : (flagged | too_long);
            // Increment beats the read clear so no event is lost
            if (too_long)
                count_out <= saturated ? count_out : count_out + 16'h0001; // R8 R11
            else if (clear_in)
                count_out <= WAKE_ERR_RESET; // R10
        end
    end

    chk_count_saturates: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // R11
        $past(count_out) == WAKE_ERR_MAX && !$past(clear_in) |-> count_out == WAKE_ERR_MAX)
        else $error("wake error counter wrapped");
endmodule : eee_wake_monitor
`default_nettype wire

// File: testbench/eee_phy_model.sv
`timescale 1ns/1ns
`default_nettype none
module eee_phy_model (
    input wire logic ref_clk_in,
    input wire logic [1:0] go_in,
    input wire logic short_in,
    input wire logic [11:0] flags_in,
    output wire eee_port_pkg::port_phy_t [1:0] phy_out
);
    import eee_port_pkg::*;
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        logic [4:0] step = 5'h00;
        logic lpi = 1'b0;
        assign phy_out[p] = '{partner: flags_in[6*p +: 6], lpi: lpi};
        // Short wake re-enters LPI and stays there, so no second fall
        always @(posedge ref_clk_in)
        begin
            if (go_in[p])
            begin
                step <= 5'h10;
                lpi <= 1'b1;
            end
            else if (step != 5'h00)
            begin
                step <= step - 5'h01;
                if (step == 5'h0E)
                    lpi <= 1'b0;
                if (step == 5'h0B && short_in)
                    lpi <= 1'b1;
            end
        end
    end
endmodule : eee_phy_model
`default_nettype wire

// File: testbench/eee_port_status_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module eee_port_status_regs_tb;
    import eee_port_pkg::*;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    host_req_t req_in = '0;
    port_phy_t [1:0] phy;
    logic [1:0] go = 2'b00;
    logic short_wake = 1'b0;
    logic [11:0] flags = 12'h000;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] adv;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    eee_port_status_regs #(.WAKE_THRESH(8)) u_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .req_in(req_in),
        .phy_in(phy), .rdata_out(rdata), .rvalid_out(rvalid), .local_tx_adv_out(adv));
    eee_phy_model u_phy (.ref_clk_in(ref_clk_in), .go_in(go), .short_in(short_wake), .flags_in(flags), .phy_out(phy));
    initial
    begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    task automatic report_and_stop();
        $display("mismatches %0d compares %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic put(input host_req_t v);
        req_in = v;
        @(posedge ref_clk_in);
        #1;
    endtask : put
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put('{1'b1, 1'b0, a, d});
    endtask : wr
    task automatic sel(input logic [2:0] t, input logic [3:0] p, input logic [7:0] o);
        wr(CTRL_ADDR, {t, 1'b0, p});
        wr(OFFSET_ADDR, o);
    endtask : sel
    task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
        put('{1'b0, 1'b1, a, 8'h00});
        cmp({7'h00, rvalid}, 8'h01);
        cmp(rdata, exp);
        put('0);
        cmp({7'h00, rvalid}, 8'h00);
    endtask : rdr
    task automatic rd(input logic [7:0] exp);
        rdr(DATA_ADDR, exp);
    endtask : rd
    task automatic rdo(input logic [2:0] t, input logic [3:0] p, input logic [7:0] o, input logic [7:0] exp);
        sel(t, p, o);
        rd(exp);
    endtask : rdo
    // Wait covers the whole model sequence plus threshold margin
    task automatic wake(input logic [1:0] p, input logic s);
        short_wake = s;
        go = p;
        @(posedge ref_clk_in);
        #1;
        go = 2'b00;
        repeat (24) @(posedge ref_clk_in);
        #1;
    endtask : wake
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (4) @(posedge ref_clk_in);
        #1;
        nrst_in = 1'b1;
        cmp({6'h00, adv}, 8'h03);
        for (int p = 3; p < 5; p++)
        begin
            rdo(TABLE_EEE, p[3:0], ABILITY_HI, 8'h00);
            rdo(TABLE_EEE, p[3:0], ABILITY_LO, 8'h02);
            rdo(TABLE_EEE, p[3:0], WAKE_ERR_HI, 8'h00);
            rdo(TABLE_EEE, p[3:0], WAKE_ERR_LO, 8'h00);
        end
        flags = {6'h15, 6'h2A};
        rdo(TABLE_EEE, 4'h3, ABILITY_HI, 8'h54);
        rdo(TABLE_EEE, 4'h4, ABILITY_HI, 8'h2A);
        rdo(TABLE_EEE, 4'h4, ABILITY_LO, 8'h02);
        sel(TABLE_EEE, 4'h3, ABILITY_LO);
        wr(DATA_ADDR, 8'hFF);
        rd(8'h02);
        wr(DATA_ADDR, 8'h00);
        rd(8'h00);
        cmp({6'h00, adv}, 8'h02);
        sel(TABLE_EEE, 4'h3, ABILITY_HI);
        wr(DATA_ADDR, 8'h00);
        rd(8'h54);
        rdo(3'h2, 4'h3, ABILITY_HI, 8'h00);
        rdr(CTRL_ADDR, 8'h43);
        rdr(OFFSET_ADDR, ABILITY_HI);
        rdo(TABLE_EEE, 4'h5, ABILITY_HI, 8'h00);
        rdo(TABLE_EEE, 4'h3, 8'h30, 8'h00);
        wake(2'b01, 1'b1);
        rdo(TABLE_EEE, 4'h3, WAKE_ERR_LO, 8'h00);
        wake(2'b10, 1'b0);
        wake(2'b10, 1'b0);
        rdo(TABLE_EEE, 4'h4, WAKE_ERR_HI, 8'h00);
        rdo(TABLE_EEE, 4'h4, WAKE_ERR_LO, 8'h02);
        rdo(TABLE_EEE, 4'h4, WAKE_ERR_LO, 8'h00);
        // Mid-run reset with a pending count and a withdrawn advertisement
        wake(2'b10, 1'b0);
        nrst_in = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        nrst_in = 1'b1;
        cmp({6'h00, adv}, 8'h03);
        rdr(CTRL_ADDR, 8'h00);
        rdo(TABLE_EEE, 4'h4, WAKE_ERR_LO, 8'h00);
        report_and_stop();
    end
endmodule : eee_port_status_regs_tb
`default_nettype wire
